// ### hdl/camera_mux_pkg.sv
package camera_mux_pkg;
    localparam int VID_W = 24;
    localparam int BANK_W = 6;
    localparam int DIP_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int FIRST_W = 10;
    localparam int SECOND_W = 12;
    localparam int THIRD_W = 14;
    localparam int DESER_W = 12;
    localparam int FIRST_SHIFT = 2;
    localparam int SECOND_SHIFT = 4;
    localparam int THIRD_SHIFT = 4;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] DATA_ADDR = 4'h8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTL_IMAGER = 0;
    localparam int CTL_VIDEO = 2;
    localparam int CTL_BANK_A = 4;
    localparam int CTL_BANK_B = 5;
    localparam int CTL_BANK_C = 6;
    localparam int CTL_CAPTURE = 7;
    localparam int ST_MODE = 7;
    localparam int ST_VALID = 8;
    localparam int ST_OVERRUN = 9;
    localparam int ST_FULL = 10;
    localparam int DATA_VALID = 31;
    localparam int DIP_IMAGER = 0;
    localparam int DIP_VIDEO = 2;
    localparam int DIP_BANK_A = 4;
    localparam int DIP_BANK_B = 5;
    localparam int DIP_BANK_C = 6;
    localparam int DIP_MODE = 7;
    localparam logic [1:0] SRC_HDMI = 2'h0;
    localparam logic [1:0] SRC_IMAGER = 2'h1;
    localparam logic [1:0] SRC_DESER = 2'h2;
    localparam logic [1:0] SRC_OFF = 2'h3;
    localparam logic [1:0] IMG_FIRST = 2'h0;
    localparam logic [1:0] IMG_SECOND = 2'h1;
    localparam logic [1:0] IMG_THIRD = 2'h2;
    localparam logic [1:0] IMG_OFF = 2'h3;
    localparam int CAM1_VS = 0;
    localparam int EXTRA_VS = 0;
    localparam int EXTRA_D10 = 1;
    localparam int EXTRA_D11 = 2;
    localparam int CAM3_EXTRA = 0;
    localparam int CAM3_BIT0 = 2;
endpackage : camera_mux_pkg

// ### hdl/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] write_ptr;
    logic [PTR_W-1:0] read_ptr;
    logic [PTR_W:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count != FULL_COUNT;
    assign out_valid = count != '0;
    assign out_data = store[read_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            store[write_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            write_ptr <= '0;
            read_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                write_ptr <= (write_ptr == LAST_PTR) ? '0 : write_ptr + 1'b1;
            end
            if (pop) begin
                read_ptr <= (read_ptr == LAST_PTR) ? '0 : read_ptr + 1'b1;
            end
            count <= count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
        end
    end
endmodule : sample_fifo

// ### hdl/camera_video_mux_demux.sv
// Notes on behaviour
// - each bank select steers six shared lines: high data, low alternates
// - bank A high: camera 6 bits 1-6; low: cam3/cam4 vsync, D10, D11
// - bank C high: camera 5 bits 1-6; low: cam1/cam2 vsync, D10, D11
// - source select: 00 HDMI, 01 imager, 10 cameras 1 and 3, 11 off
// - imager select: 00 first, 01 second, 10 third sensor, 11 off
// - mode switch picks DIP switch (0) or software controls (1)
// - manual: DIP 2-1 give imager select, DIP 4-3 give source select
// - manual: DIP 5, 6, 7 give bank A, B, C selects
// - bank B select also picks imager data mode: low shift, high straight
// - first type: shift gives 00 and bits 9-2, straight bits 9-0
// - second type: shift gives 0000 and bits 11-4, straight 11-0
// - third type: shift gives 0000 and bits 13-4, straight 13-0
// - split and source routing live in this logic to bound video delay
`timescale 1ns/1ps
module camera_video_mux_demux
    import camera_mux_pkg::*;
#(
    parameter int CAPTURE_DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [DIP_W-1:0] dip_switch,
    input wire logic [BANK_W-1:0] shared_bank_a,
    input wire logic [BANK_W-1:0] shared_bank_b,
    input wire logic [BANK_W-1:0] shared_bank_c,
    output logic [BANK_W-1:0] cam6_upper_bits,
    output logic [BANK_W-1:0] cam34_extra_bits,
    output logic [BANK_W-1:0] cam_bit0,
    output logic [BANK_W-1:0] cam_vertical_sync,
    output logic [BANK_W-1:0] cam5_upper_bits,
    output logic [BANK_W-1:0] cam12_extra_bits,
    input wire logic [9:1] cam1_mid_bits,
    input wire logic cam1_horizontal_sync,
    input wire logic cam1_pclk,
    input wire logic [9:1] cam3_mid_bits,
    input wire logic [VID_W-1:0] hdmi_data,
    input wire logic hdmi_horizontal_sync,
    input wire logic hdmi_vertical_sync,
    input wire logic hdmi_pclk,
    input wire logic [FIRST_W-1:0] first_data,
    input wire logic first_horizontal_sync,
    input wire logic first_vertical_sync,
    input wire logic first_pclk,
    input wire logic [SECOND_W-1:0] second_data,
    input wire logic second_horizontal_sync,
    input wire logic second_vertical_sync,
    input wire logic second_pclk,
    input wire logic [THIRD_W-1:0] third_data,
    input wire logic third_horizontal_sync,
    input wire logic third_vertical_sync,
    input wire logic third_pclk,
    output logic [VID_W-1:0] video_data,
    output logic video_horizontal_sync,
    output logic video_vertical_sync,
    output logic video_pclk,
    output logic video_out_en,
    output logic [1:0] imager_source_select,
    output logic [1:0] video_source_select,
    output logic bank_a_split_select,
    output logic bank_b_split_select,
    output logic bank_c_split_select
);
    function automatic logic pick(input logic software,
                                  input logic sw_bit,
                                  input logic dip_bit);
        return software ? sw_bit : dip_bit;
    endfunction : pick

    function automatic logic [BANK_W-1:0] split(input logic level,
                                                input logic want,
                                                input logic [BANK_W-1:0] v);
        return (level == want) ? v : '0;
    endfunction : split

    // synchronised DIP switch
    logic [DIP_W-1:0] dip_meta;
    logic [DIP_W-1:0] dip_sync;
    logic [7:0] ctrl;
    logic overrun;
    logic software_mode;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dip_meta <= '0;
            dip_sync <= '0;
        end else begin
            dip_meta <= dip_switch;
            dip_sync <= dip_meta;
        end
    end

    // select sources
    assign software_mode = dip_sync[DIP_MODE];
    generate
        for (genvar i = 0; i < 2; i++) begin : g_two_bit
            assign imager_source_select[i] = pick(software_mode,
                ctrl[CTL_IMAGER + i], dip_sync[DIP_IMAGER + i]);
            assign video_source_select[i] = pick(software_mode,
                ctrl[CTL_VIDEO + i], dip_sync[DIP_VIDEO + i]);
        end
    endgenerate
    assign bank_a_split_select = pick(software_mode, ctrl[CTL_BANK_A],
        dip_sync[DIP_BANK_A]);
    assign bank_b_split_select = pick(software_mode, ctrl[CTL_BANK_B],
        dip_sync[DIP_BANK_B]);
    assign bank_c_split_select = pick(software_mode, ctrl[CTL_BANK_C],
        dip_sync[DIP_BANK_C]);

    // shared line split, combinational
    assign cam6_upper_bits = split(bank_a_split_select, 1'b1,
        shared_bank_a);
    assign cam34_extra_bits = split(bank_a_split_select, 1'b0,
        shared_bank_a);
    assign cam_bit0 = split(bank_b_split_select, 1'b1,
        shared_bank_b);
    assign cam_vertical_sync = split(bank_b_split_select, 1'b0,
        shared_bank_b);
    assign cam5_upper_bits = split(bank_c_split_select, 1'b1,
        shared_bank_c);
    assign cam12_extra_bits = split(bank_c_split_select, 1'b0,
        shared_bank_c);

    // deserialized cameras 1 and 3 assembled into one word
    wire [DESER_W-1:0] cam1_word = {cam12_extra_bits[EXTRA_D11],
        cam12_extra_bits[EXTRA_D10], cam1_mid_bits, cam_bit0[0]};
    wire [DESER_W-1:0] cam3_word = {cam34_extra_bits[EXTRA_D11],
        cam34_extra_bits[EXTRA_D10], cam3_mid_bits, cam_bit0[CAM3_BIT0]};
    // vsync arrives on bank C in the 12-bit setup, on bank B otherwise
    wire cam1_vsync = bank_c_split_select ? cam_vertical_sync[CAM1_VS]
        : cam12_extra_bits[EXTRA_VS];

    // imager data mode
    wire straight = bank_b_split_select;
    wire [FIRST_W-1:0] first_word = straight ? first_data
        : first_data >> FIRST_SHIFT;
    wire [SECOND_W-1:0] second_word = straight ? second_data
        : second_data >> SECOND_SHIFT;
    wire [THIRD_W-1:0] third_word = straight ? third_data
        : third_data >> THIRD_SHIFT;

    // imager level
    logic [VID_W-1:0] imager_data;
    logic imager_hsync;
    logic imager_vsync;
    logic imager_pclk;
    always_comb begin
        imager_data = '0;
        imager_hsync = 1'b0;
        imager_vsync = 1'b0;
        imager_pclk = 1'b0;
        case (imager_source_select)
            IMG_FIRST: begin
                imager_data = VID_W'(first_word);
                imager_hsync = first_horizontal_sync;
                imager_vsync = first_vertical_sync;
                imager_pclk = first_pclk;
            end
            IMG_SECOND: begin
                imager_data = VID_W'(second_word);
                imager_hsync = second_horizontal_sync;
                imager_vsync = second_vertical_sync;
                imager_pclk = second_pclk;
            end
            IMG_THIRD: begin
                imager_data = VID_W'(third_word);
                imager_hsync = third_horizontal_sync;
                imager_vsync = third_vertical_sync;
                imager_pclk = third_pclk;
            end
            default: begin
                imager_data = '0;
            end
        endcase
    end

    // source level
    always_comb begin
        video_data = '0;
        video_horizontal_sync = 1'b0;
        video_vertical_sync = 1'b0;
        video_pclk = 1'b0;
        case (video_source_select)
            SRC_HDMI: begin
                video_data = hdmi_data;
                video_horizontal_sync = hdmi_horizontal_sync;
                video_vertical_sync = hdmi_vertical_sync;
                video_pclk = hdmi_pclk;
            end
            SRC_IMAGER: begin
                video_data = imager_data;
                video_horizontal_sync = imager_hsync;
                video_vertical_sync = imager_vsync;
                video_pclk = imager_pclk;
            end
            SRC_DESER: begin
                video_data = {cam3_word, cam1_word};
                video_horizontal_sync = cam1_horizontal_sync;
                video_vertical_sync = cam1_vsync;
                video_pclk = cam1_pclk;
            end
            default: begin
                video_data = '0;
            end
        endcase
    end
    assign video_out_en = (video_source_select != SRC_OFF)
        && !(video_source_select == SRC_IMAGER
        && imager_source_select == IMG_OFF);

    // capture monitor: samples the routed word at each pixel clock rise
    logic [VID_W-1:0] data_meta;
    logic [VID_W-1:0] data_sync;
    logic [2:0] pclk_meta;
    logic [2:0] pclk_sync;
    logic pclk_prev;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_meta <= '0;
            data_sync <= '0;
            pclk_meta <= '0;
            pclk_sync <= '0;
            pclk_prev <= 1'b0;
        end else begin
            data_meta <= video_data;
            data_sync <= data_meta;
            pclk_meta <= {video_out_en, video_pclk, 1'b0};
            pclk_sync <= pclk_meta;
            pclk_prev <= pclk_sync[1];
        end
    end
    wire pclk_rise = pclk_sync[1] && !pclk_prev && pclk_sync[2];
    wire capture_push = pclk_rise && ctrl[CTL_CAPTURE];
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [VID_W-1:0] fifo_data;

    sample_fifo #(
        .WIDTH(VID_W),
        .DEPTH(CAPTURE_DEPTH)
    ) u_capture (
        .clock(clock),
        .rst(rst),
        .in_valid(capture_push),
        .in_ready(fifo_ready),
        .in_data(data_sync),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // wishbone slave, one wait state
    wire request = cyc_i && stb_i && !ack_o;
    wire hit_ctrl = adr_i == CTRL_ADDR;
    wire hit_status = adr_i == STATUS_ADDR;
    wire hit_data = adr_i == DATA_ADDR;
    wire ctrl_write = request && we_i && hit_ctrl && sel_i[0];
    wire overrun_clear = request && we_i && hit_status && sel_i[1]
        && dat_i[ST_OVERRUN];
    wire overrun_set = capture_push && !fifo_ready;
    assign fifo_pop = request && !we_i && hit_data;
    wire [31:0] status_word = 32'({fifo_ready == 1'b0, overrun,
        fifo_valid, software_mode, bank_c_split_select,
        bank_b_split_select, bank_a_split_select, video_source_select,
        imager_source_select});
    wire [31:0] data_word = {fifo_valid, 7'h00, fifo_data};
    wire [31:0] next_dat = hit_ctrl ? {24'h000000, ctrl}
        : hit_status ? status_word
        : hit_data ? data_word : 32'h00000000;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= '0;
            ctrl <= CTRL_RESET;
            overrun <= 1'b0;
        end else begin
            ack_o <= request;
            dat_o <= (request && !we_i) ? next_dat : 32'h00000000;
            if (ctrl_write) begin
                ctrl <= dat_i[7:0];
            end
            // a new overrun wins over a clear in the same cycle
            overrun <= overrun_set || (overrun && !overrun_clear);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_bank_a_high: assert property (
        bank_a_split_select |-> cam6_upper_bits == shared_bank_a
        && cam34_extra_bits == '0)
        else $error("bank A high routing wrong");
    a_bank_a_low: assert property (
        !bank_a_split_select |-> cam34_extra_bits == shared_bank_a
        && cam6_upper_bits == '0)
        else $error("bank A low routing wrong");
    a_bank_b_split: assert property (
        cam_bit0 == (bank_b_split_select ? shared_bank_b : '0)
        && cam_vertical_sync == (bank_b_split_select ? '0 : shared_bank_b))
        else $error("bank B routing wrong");
    a_bank_c_split: assert property (
        cam5_upper_bits == (bank_c_split_select ? shared_bank_c : '0)
        && cam12_extra_bits == (bank_c_split_select ? '0 : shared_bank_c))
        else $error("bank C routing wrong");
    a_source_hdmi: assert property (
        video_source_select == SRC_HDMI |-> video_out_en
        && video_data == hdmi_data && video_pclk == hdmi_pclk)
        else $error("hdmi source not routed");
    a_source_off: assert property (
        video_source_select == SRC_OFF |-> !video_out_en)
        else $error("output driven while source off");
    a_imager_off: assert property (
        video_source_select == SRC_IMAGER && imager_source_select == IMG_OFF
        |-> !video_out_en)
        else $error("output driven while imager off");
    a_manual_mode: assert property (
        $stable(dip_switch) [*3] ##0 !dip_switch[DIP_MODE]
        |-> imager_source_select == dip_switch[DIP_IMAGER +: 2]
        && video_source_select == dip_switch[DIP_VIDEO +: 2])
        else $error("manual selects not from switch");
    a_software_mode: assert property (
        $stable(dip_switch) [*3] ##0 dip_switch[DIP_MODE]
        |-> bank_b_split_select == ctrl[CTL_BANK_B]
        && video_source_select == ctrl[CTL_VIDEO +: 2])
        else $error("software selects not applied");
    a_shift_first: assert property (
        video_source_select == SRC_IMAGER && imager_source_select == IMG_FIRST
        && !bank_b_split_select
        |-> video_data == VID_W'(first_data[9:2]))
        else $error("first sensor shift wrong");
    a_straight_second: assert property (
        video_source_select == SRC_IMAGER && imager_source_select == IMG_SECOND
        && bank_b_split_select |-> video_data == VID_W'(second_data))
        else $error("second sensor straight wrong");
    a_shift_third: assert property (
        video_source_select == SRC_IMAGER && imager_source_select == IMG_THIRD
        && !bank_b_split_select
        |-> video_data == VID_W'(third_data[13:4]))
        else $error("third sensor shift wrong");
    a_ack_single: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle");
    a_overrun_sticky: assert property (
        overrun_set |=> overrun)
        else $error("overrun lost");

    c_hdmi_out: cover property (video_source_select == SRC_HDMI
        && video_out_en);
    c_deser_out: cover property (video_source_select == SRC_DESER);
    c_capture: cover property (capture_push && fifo_ready);
    c_overrun: cover property (overrun_set);
endmodule : camera_video_mux_demux

// ### sim/camera_far_side.sv
`timescale 1ns/1ps
module camera_far_side
    import camera_mux_pkg::*;
(
    output logic pclk,
    output logic hsync,
    output logic vsync,
    output logic [FIRST_W-1:0] data
);
    initial begin
        pclk = 1'b0;
        hsync = 1'b0;
        vsync = 1'b0;
        data = 10'h2b5;
    end
    // pixel clock only runs inside a frame; data moves on the falling edge
    task automatic send_frame(input logic [FIRST_W-1:0] base, input int n);
        vsync = 1'b1;
        hsync = 1'b1;
        for (int i = 0; i < n; i++) begin
            data = base + FIRST_W'(i);
            #62.5 pclk = 1'b1;
            #62.5 pclk = 1'b0;
        end
        hsync = 1'b0;
        vsync = 1'b0;
    endtask : send_frame
endmodule : camera_far_side

// ### sim/tb_top.sv
`timescale 1ns/1ps
`define chk(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected %s expected %h seen %h", nm, e, g); \
    end end
module tb_top;
    import camera_mux_pkg::*;
    logic clock = 1'b0, rst = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rdata;
    logic [DIP_W-1:0] dip_switch = 8'h80;
    logic [BANK_W-1:0] shared_bank_a = 6'h2d, shared_bank_b = 6'h1b;
    logic [BANK_W-1:0] shared_bank_c = 6'h36;
    logic [BANK_W-1:0] cam6_upper_bits, cam34_extra_bits, cam_bit0;
    logic [BANK_W-1:0] cam_vertical_sync, cam5_upper_bits, cam12_extra_bits;
    logic [9:1] cam1_mid_bits = 9'h1a5, cam3_mid_bits = 9'h0d3;
    logic [3:0] hsync_in = 4'h5, vsync_in = 4'ha, pc = 4'h6;
    logic [VID_W-1:0] hdmi_data = 24'h5a3c96, video_data;
    logic [SECOND_W-1:0] second_data = 12'hb6d;
    logic [THIRD_W-1:0] third_data = 14'h2e5b;
    logic [FIRST_W-1:0] first_data;
    logic first_hsync, first_vsync, first_pclk;
    logic video_hsync, video_vsync, video_pclk, video_out_en;
    logic [1:0] imager_source_select, video_source_select;
    logic bank_a_split_select, bank_b_split_select, bank_c_split_select;
    int n_mismatch = 0, comparisons = 0, cycles = 0;

    always #5 clock = ~clock;

    camera_video_mux_demux #(.CAPTURE_DEPTH(FIFO_DEPTH))
    u_camera_video_mux_demux (
        .clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .dip_switch, .shared_bank_a, .shared_bank_b, .shared_bank_c,
        .cam6_upper_bits, .cam34_extra_bits, .cam_bit0, .cam_vertical_sync,
        .cam5_upper_bits, .cam12_extra_bits, .cam1_mid_bits,
        .cam1_horizontal_sync(hsync_in[3]), .cam1_pclk(pc[3]),
        .cam3_mid_bits, .hdmi_data, .hdmi_horizontal_sync(hsync_in[0]),
        .hdmi_vertical_sync(vsync_in[0]), .hdmi_pclk(pc[0]), .first_data,
        .first_horizontal_sync(first_hsync),
        .first_vertical_sync(first_vsync), .first_pclk, .second_data,
        .second_horizontal_sync(hsync_in[1]),
        .second_vertical_sync(vsync_in[1]), .second_pclk(pc[1]),
        .third_data, .third_horizontal_sync(hsync_in[2]),
        .third_vertical_sync(vsync_in[2]), .third_pclk(pc[2]), .video_data,
        .video_horizontal_sync(video_hsync),
        .video_vertical_sync(video_vsync),
        .video_pclk, .video_out_en, .imager_source_select,
        .video_source_select, .bank_a_split_select, .bank_b_split_select,
        .bank_c_split_select
    );

    camera_far_side u_camera_far_side (
        .pclk(first_pclk), .hsync(first_hsync), .vsync(first_vsync),
        .data(first_data)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("unexpected timeout");
            tally_and_finish();
        end
    end

    // one classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clock); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic set_ctrl(input logic [7:0] v);
        wb(1'b1, CTRL_ADDR, {24'h0, v}, rdata);
        repeat (2) @(posedge clock);
    endtask : set_ctrl

    // {enable, hsync, vsync, pclk, word} for {source, imager} and bank B
    function automatic logic [VID_W+3:0] exp_vid(input logic [3:0] s,
            input logic b);
        case (s)
            4'h0, 4'h1, 4'h2, 4'h3: return {1'b1, hsync_in[0], vsync_in[0],
                pc[0], hdmi_data};
            4'h4: return {1'b1, first_hsync, first_vsync, first_pclk, b ?
                VID_W'(first_data) : VID_W'(first_data[9:2])};
            4'h5: return {1'b1, hsync_in[1], vsync_in[1], pc[1], b ?
                VID_W'(second_data) : VID_W'(second_data[11:4])};
            4'h6: return {1'b1, hsync_in[2], vsync_in[2], pc[2], b ?
                VID_W'(third_data) : VID_W'(third_data[13:4])};
            // bank C runs opposite to bank B, so both vsync paths are used
            4'h8, 4'h9, 4'ha, 4'hb: return {1'b1, hsync_in[3],
                b ? shared_bank_c[0] : shared_bank_b[0], pc[3],
                shared_bank_a[2:1], cam3_mid_bits, b & shared_bank_b[2],
                b ? shared_bank_c[2:1] : 2'b00, cam1_mid_bits,
                b & shared_bank_b[0]};
            default: return '0;
        endcase
    endfunction : exp_vid

    task automatic t_demux();
        logic [2:0] cfg [4];
        logic a, b, c;
        cfg = '{3'b101, 3'b111, 3'b010, 3'b000};
        foreach (cfg[i]) begin
            set_ctrl({1'b0, cfg[i][0], cfg[i][1], cfg[i][2], 4'h0});
            {shared_bank_a, shared_bank_b} <= ~{shared_bank_a, shared_bank_b};
            {a, b, c} = cfg[i];
            @(negedge clock);
            `chk("selects", cfg[i], {bank_a_split_select, bank_b_split_select,
                bank_c_split_select})
            `chk("cam6", a ? shared_bank_a : '0, cam6_upper_bits)
            `chk("cam34", a ? '0 : shared_bank_a, cam34_extra_bits)
            `chk("bit0", b ? shared_bank_b : '0, cam_bit0)
            `chk("vsync", b ? '0 : shared_bank_b, cam_vertical_sync)
            `chk("cam5", c ? shared_bank_c : '0, cam5_upper_bits)
            `chk("cam12", c ? '0 : shared_bank_c, cam12_extra_bits)
        end
    endtask : t_demux

    task automatic t_source();
        logic [VID_W+3:0] got;
        logic [VID_W+3:0] want;
        logic [VID_W-1:0] word;
        for (int k = 0; k < 32; k++) begin
            set_ctrl({1'b0, ~k[4], k[4], 1'b0, k[3:0]});
            @(negedge clock);
            got = {video_out_en, video_hsync, video_vsync, video_pclk,
                video_data};
            want = exp_vid(k[3:0], k[4]);
            word = want[VID_W-1:0];
            `chk("video", want, got)
            `chk("mode", word, video_data)
        end
    endtask : t_source

    task automatic t_manual();
        logic [7:0] d [2];
        d = '{8'h1b, 8'h66};
        foreach (d[i]) begin
            set_ctrl(~d[i] & 8'h7f);
            dip_switch <= d[i];
            repeat (4) @(posedge clock);
            wb(1'b0, STATUS_ADDR, 32'h0, rdata);
            @(negedge clock);
            `chk("img_sel", d[i][1:0], imager_source_select)
            `chk("src_sel", d[i][3:2], video_source_select)
            `chk("banks", d[i][6:4], {bank_c_split_select,
                bank_b_split_select, bank_a_split_select})
            `chk("status", d[i], rdata[7:0])
        end
        dip_switch <= 8'h80;
        repeat (4) @(posedge clock);
    endtask : t_manual

    task automatic t_capture();
        set_ctrl(8'ha4);
        #3;
        u_camera_far_side.send_frame(10'h100, 6);
        repeat (10) @(posedge clock);
        wb(1'b0, STATUS_ADDR, 32'h0, rdata);
        `chk("flags_full", 3'b111, rdata[10:8])
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, DATA_ADDR, 32'h0, rdata);
            `chk("valid", i < 4, rdata[31])
            if (i < 4) `chk("word", VID_W'(10'h100 + i), rdata[23:0])
        end
        wb(1'b1, STATUS_ADDR, 32'h200, rdata);
        wb(1'b0, STATUS_ADDR, 32'h0, rdata);
        `chk("flags_empty", 3'b000, rdata[10:8])
        wb(1'b0, 4'hc, 32'h0, rdata);
        `chk("unmapped", 32'h0, rdata)
    endtask : t_capture

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_demux();
        t_source();
        t_manual();
        t_capture();
        tally_and_finish();
    end
endmodule : tb_top
